// ===== pss_host_model.sv
// bus host model: issues register writes and reads to the sequencer
// assumes a synchronous strobe interface sampled on the clock's rising edge
`timescale 1ns/10ps
module pss_host_model (
    input wire logic clk_i, // core clock
    output logic wr_o, // write strobe
    output logic [15:0] addr_o, // register address
    output logic [15:0] wdata_o, // write data
    input wire logic [15:0] rdata_i // read data
);
    initial begin
        wr_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end
    // ----------------------------------------
    // transfers
    // ----------------------------------------
    // strobe drops one edge later, so back-to-back calls leave a gap cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // read data is registered, so it is taken two edges after the address
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        @(posedge clk_i);
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule // pss_host_model

// ===== pss_pkg.sv
// package of constants for the power sequencing and soft start block
// assumes a 10 MHz core clock and settings registers reached by address
package pss_pkg;
    localparam logic [15:0] REG_OPERATION = 16'h0001;
    localparam logic [15:0] REG_ON_OFF_CFG = 16'h0002;
    localparam logic [15:0] REG_UV_LIMIT = 16'h0044;
    localparam logic [15:0] REG_TON_DLY = 16'h0060;
    localparam logic [15:0] REG_TURN_ON_RISE_TIME = 16'h0061;
    localparam logic [15:0] REG_TON_MAX = 16'h0062;
    localparam logic [15:0] REG_TOFF_DLY = 16'h0064;
    localparam logic [15:0] REG_TURN_OFF_FALL_TIME = 16'h0065;
    localparam logic [15:0] REG_TOFF_MAX = 16'h0066;
    localparam logic [15:0] REG_BASE_ADDR = 16'h00D0;
    localparam logic [15:0] REG_OV_RESP = 16'hFE4D;
    localparam logic [15:0] REG_SS_OPT = 16'hFE51;
    localparam logic [15:0] REG_STATUS = 16'hFE70;
    localparam int OP_ON_BIT = 7;
    localparam int CFG_PIN_BIT = 2;
    localparam int CFG_CMD_BIT = 3;
    localparam int CFG_ALWAYS_BIT = 4;
    localparam int OV_IGNORE_BIT = 7;
    localparam int OV_RELOAD_BIT = 6;
    localparam int OV_DEB_BIT = 5;
    localparam int PRECHARGE_BIT = 0;
    localparam logic [10:0] DELAY_MAX_MS = 11'h400;
    localparam logic [10:0] RAMP_MAX_MS = 11'h064;
    localparam logic [7:0] OV_RESP_RST = 8'h80;
    localparam logic [7:0] ON_OFF_RST = 8'h17;
    localparam int CLK_HZ = 10000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    localparam int IDLE_MS = 4;
    localparam int ERASE_MS = 35;
    localparam int OV_DEB_MS = 1;
endpackage

// ===== pss_tb.sv
// self-checking bench for the power sequencing and soft start block
// assumes the host model above and a 10 MHz clock with 1 ms ticks
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b0;
    logic ov = 1'b0;
    logic ctrl = 1'b0;
    logic erase_need = 1'b0;
    logic load_done = 1'b0;
    logic [1:0] addr_pin = 2'b10;
    logic [11:0] target = 12'h000;
    logic [11:0] sense = 12'h000;
    logic wr, load_req, ready, sw, st_fault, ov_fault;
    logic [15:0] addr, wdata, rdata;
    logic [6:0] slave_addr;
    logic [11:0] ref_v;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h48838E47;
    logic [15:0] tregs [4] = '{pss_pkg::REG_TON_DLY, pss_pkg::REG_TURN_ON_RISE_TIME,
        pss_pkg::REG_TOFF_DLY, pss_pkg::REG_TURN_OFF_FALL_TIME};

    always #50 clk = ~clk;

    pss_top #(.REF_W(12)) dut (.CLK_I(clk), .RST_N_I(rst_n),
        .SUPPLY_OK_I(supply_ok), .OV_I(ov), .CTRL_I(ctrl),
        .ADDR_PIN_I(addr_pin), .ERASE_NEED_I(erase_need),
        .LOAD_DONE_I(load_done), .WR_I(wr), .ADDR_I(addr), .WDATA_I(wdata),
        .TARGET_I(target), .SENSE_I(sense), .LOAD_REQ_O(load_req),
        .SLAVE_ADDR_O(slave_addr), .READY_O(ready), .REF_O(ref_v),
        .SWITCH_O(sw), .START_FAULT_O(st_fault), .OV_FAULT_O(ov_fault),
        .RDATA_O(rdata));

    pss_host_model host (.clk_i(clk), .wr_o(wr), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // quarter-ms code rounded to whole ms, clamped, shown back as ms*4
    function automatic logic [15:0] rnd_ms(input logic [15:0] v, input int lim);
        int ms;
        ms = (int'(v) + 2) / 4;
        if (ms > lim) ms = lim;
        return 16'(ms * 4);
    endfunction
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin : main
        logic [31:0] r;
        logic [15:0] v, d;
        logic [11:0] prev;
        logic ok, half;
        int cnt;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        r = xs();
        supply_ok <= 1'b1;
        target <= (r[11:0] & 12'hFFE) | 12'h002;
        sense <= r[27:16];
        cnt = 0;
        while (load_req !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            cnt++;
        end
        chk("load request", 16'h0001, {15'h0000, load_req});
        ov <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            r = xs();
            v = (i < 4) ? 16'hFFFF : r[15:0];
            if (v[1:0] == 2'b10) v[0] = 1'b1;
            host.wr(tregs[i % 4], v);
            host.rd(tregs[i % 4], d);
            chk("time register", rnd_ms(v, (i % 2 == 0) ?
                int'(pss_pkg::DELAY_MAX_MS) : int'(pss_pkg::RAMP_MAX_MS)), d);
        end
        host.wr(16'h0077, 16'h1234);
        host.rd(16'h0077, d);
        chk("unmapped read", 16'h0000, d);
        host.wr(pss_pkg::REG_TON_DLY, 16'h0000);
        host.wr(pss_pkg::REG_TURN_ON_RISE_TIME, 16'h0008);
        host.wr(pss_pkg::REG_TOFF_DLY, 16'h0000);
        host.wr(pss_pkg::REG_TURN_OFF_FALL_TIME, 16'h0004);
        host.wr(pss_pkg::REG_UV_LIMIT, 16'h0000);
        host.wr(pss_pkg::REG_ON_OFF_CFG, 16'h0000);
        host.wr(pss_pkg::REG_BASE_ADDR, 16'h005C);
        ov <= 1'b0;
        @(posedge clk);
        load_done <= 1'b1;
        @(posedge clk);
        load_done <= 1'b0;
        repeat (3) @(posedge clk);
        chk("ov during load", 16'h0000, {15'h0000, ov_fault});
        chk("slave address", 16'h005E, {9'h000, slave_addr});
        cnt = 0;
        while (ready !== 1'b1 && cnt < 6 * pss_pkg::TICK_CYC) begin
            @(posedge clk);
            cnt++;
        end
        ok = cnt >= 4 * pss_pkg::TICK_CYC - 8 &&
             cnt <= 5 * pss_pkg::TICK_CYC;
        chk("idle length", 16'h0001, {15'h0000, ok});
        chk("ref at ready", 16'h0000, {4'h0, ref_v});
        // ramp of 2 ms: only 0, half and full target may ever appear
        prev = 12'h000;
        half = 1'b0;
        repeat (64) begin
            repeat (500) @(posedge clk);
            ok = (ref_v === 12'h000 || ref_v === target / 2 ||
                  ref_v === target) && ref_v >= prev;
            chk("ramp step", 16'h0001, {15'h0000, ok});
            if (ref_v === target / 2) half = 1'b1;
            prev = ref_v;
        end
        chk("ramp end", {4'h0, target}, {4'h0, ref_v});
        chk("ramp midpoint", 16'h0001, {15'h0000, half});
        chk("switching on", 16'h0001, {15'h0000, sw});
        chk("start fault", 16'h0000, {15'h0000, st_fault});
        // command control with operation off asks for a soft stop
        host.wr(pss_pkg::REG_ON_OFF_CFG, 16'h0018);
        repeat (20) begin
            repeat (1000) @(posedge clk);
            ok = ref_v === 12'h000 || ref_v === target;
            chk("fall step", 16'h0001, {15'h0000, ok});
        end
        chk("fall end", 16'h0000, {4'h0, ref_v});
        chk("switching off", 16'h0000, {15'h0000, sw});
        // pin control: status shows the one-hot state word
        host.wr(pss_pkg::REG_TON_DLY, 16'h0014);
        host.wr(pss_pkg::REG_ON_OFF_CFG, 16'h0014);
        ctrl <= 1'b1;
        host.rd(pss_pkg::REG_STATUS, d);
        chk("pin on state", 16'h0010, d);
        ctrl <= 1'b0;
        host.rd(pss_pkg::REG_STATUS, d);
        chk("pin off state", 16'h0008, d);
        host.wr(pss_pkg::REG_OV_RESP, 16'h0000);
        ov <= 1'b1;
        repeat (5) @(posedge clk);
        ov <= 1'b0;
        repeat (20) @(posedge clk);
        chk("ov fault", 16'h0001, {15'h0000, ov_fault});
        chk("ready after ov", 16'h0000, {15'h0000, ready});
        // reload response: fault asks for a fresh load, held overvoltage
        // must not restart it while the load is under way
        host.wr(pss_pkg::REG_OV_RESP, 16'h0040);
        ov <= 1'b1;
        cnt = 0;
        while (load_req !== 1'b1 && cnt < 20) begin
            @(posedge clk);
            cnt++;
        end
        chk("reload request", 16'h0001, {15'h0000, load_req});
        host.rd(pss_pkg::REG_STATUS, d);
        chk("load state held", 16'h0002, d);
        chk("no repeat load", 16'h0000, {15'h0000, load_req});
        ov <= 1'b0;
        stop_test();
    end

    // about 102k cycles of traffic are expected; give some margin
    initial begin : watchdog
        repeat (120000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
endmodule // testbench

// ===== pss_top.sv
// power-up sequencing, soft start/stop ramps and supply overvoltage lockout
// assumes a settings loader handshake and synchronous register strobes
//
// How it works
// - delays 0..1024 ms, 1 ms steps
// - ramp times 0..100 ms, 1 ms steps
// - round to step, clamp to range
// - load page one after supply good
// - address from base register bits 6..2 with pin code as low bits
// - idle wait, plus 35 ms if erasing
// - after idle, start if operation enabled
// - config bit 4 low means always on
// - wait on delay then ramp reference
// - output must pass uv limit before max
// - uv limit zero disables turn-on max check
// - precharge option starts from sensed output
// - soft stop mirrors soft start
// - overvoltage handled by bits 7..5
// - ignore overvoltage while loading
// - 4 ms idle after every load
// - before first load overvoltage ignored
`timescale 1ns/10ps
module pss_top #(
    parameter int REF_W = 12
) (
    input wire logic CLK_I, // core clock
    input wire logic RST_N_I, // core power-on reset
    input wire logic SUPPLY_OK_I, // supply above lockout and core up
    input wire logic OV_I, // supply or core overvoltage
    input wire logic CTRL_I, // hardware power-on request
    input wire logic [1:0] ADDR_PIN_I, // address select pin code
    input wire logic ERASE_NEED_I, // recorder page erase pending
    input wire logic LOAD_DONE_I, // settings load finished
    input wire logic WR_I, // register write strobe
    input wire logic [15:0] ADDR_I, // register address
    input wire logic [15:0] WDATA_I, // write data
    input wire logic [REF_W-1:0] TARGET_I, // regulation reference target
    input wire logic [REF_W-1:0] SENSE_I, // sensed output voltage
    output logic LOAD_REQ_O, // request settings load
    output logic [6:0] SLAVE_ADDR_O, // resolved bus address
    output logic READY_O, // idle done
    output logic [REF_W-1:0] REF_O, // digital reference
    output logic SWITCH_O, // outputs switching
    output logic START_FAULT_O, // start or stop timeout
    output logic OV_FAULT_O, // overvoltage fault
    output logic [15:0] RDATA_O // read data
);
    typedef enum logic [8:0] {
        S_RESET = 9'h001, S_LOAD = 9'h002, S_IDLE = 9'h004,
        S_OFF = 9'h008, S_ONDLY = 9'h010, S_RISE = 9'h020,
        S_ON = 9'h040, S_OFFDLY = 9'h080, S_FALL = 9'h100
    } pss_state_t;

    typedef struct packed {
        pss_state_t st;
        logic [7:0] op, cfg, base, ovr, opt;
        logic [10:0] ton_d, ton_r, ton_m, tof_d, tof_f, tof_m;
        logic [15:0] uv;
        logic [15:0] pre;
        logic [10:0] ms;
        logic [10:0] tmax;
        logic [REF_W-1:0] ref_v, start_v;
        logic loaded, load_req, ready, sw, sf, ovf, ov_seen;
        logic [6:0] sa;
        logic [15:0] rd;
        logic [15:0] div;
        logic tick;
    } pss_reg_t;

    pss_reg_t r, next_r;
    logic tick;
    logic on_req;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // values are in units of 1/4 ms; round to nearest ms and clamp
    function automatic logic [10:0] pss_ms(input logic [15:0] v,
                                           input logic [10:0] lim);
        logic [16:0] m;
        // one spare bit so a code near full scale cannot wrap past zero
        m = ({1'b0, v} + 17'h00002) >> 2;
        if (m > {6'h00, lim}) pss_ms = lim;
        else pss_ms = m[10:0];
    endfunction

    // reference at elapsed ms of a ramp of t ms between two levels
    function automatic logic [REF_W-1:0] pss_lerp(
        input logic [REF_W-1:0] a, input logic [REF_W-1:0] b,
        input logic [10:0] n, input logic [10:0] t);
        logic [REF_W+11:0] p;
        p = '0;
        if (t == 11'h000 || n >= t) pss_lerp = b;
        else if (b >= a) begin
            p = {12'h000, b - a} * n / t;
            pss_lerp = a + p[REF_W-1:0];
        end else begin
            p = {12'h000, a - b} * n / t;
            pss_lerp = a - p[REF_W-1:0];
        end
    endfunction

    // --------------------------------------------------------------
    // millisecond tick
    // --------------------------------------------------------------
    // divider lives in the state record; tick is its registered wrap pulse
    assign tick = r.tick;

    // --------------------------------------------------------------
    // power request decode
    // --------------------------------------------------------------
    always_comb begin
        on_req = 1'b1;
        if (r.cfg[pss_pkg::CFG_ALWAYS_BIT]) begin
            if (r.cfg[pss_pkg::CFG_CMD_BIT] && !r.op[pss_pkg::OP_ON_BIT])
                on_req = 1'b0;
            if (r.cfg[pss_pkg::CFG_PIN_BIT] && !CTRL_I)
                on_req = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.load_req = 1'b0;
        next_r.tick = (r.div == 16'(pss_pkg::TICK_CYC - 1));
        next_r.div = next_r.tick ? 16'h0000 : r.div + 16'h0001;
        if (WR_I) begin
            case (ADDR_I)
                pss_pkg::REG_OPERATION: next_r.op = WDATA_I[7:0];
                pss_pkg::REG_ON_OFF_CFG: next_r.cfg = WDATA_I[7:0];
                pss_pkg::REG_UV_LIMIT: next_r.uv = WDATA_I;
                pss_pkg::REG_TON_DLY:
                    next_r.ton_d = pss_ms(WDATA_I, pss_pkg::DELAY_MAX_MS);
                pss_pkg::REG_TURN_ON_RISE_TIME:
                    next_r.ton_r = pss_ms(WDATA_I, pss_pkg::RAMP_MAX_MS);
                pss_pkg::REG_TON_MAX:
                    next_r.ton_m = pss_ms(WDATA_I, pss_pkg::DELAY_MAX_MS);
                pss_pkg::REG_TOFF_DLY:
                    next_r.tof_d = pss_ms(WDATA_I, pss_pkg::DELAY_MAX_MS);
                pss_pkg::REG_TURN_OFF_FALL_TIME:
                    next_r.tof_f = pss_ms(WDATA_I, pss_pkg::RAMP_MAX_MS);
                pss_pkg::REG_TOFF_MAX:
                    next_r.tof_m = pss_ms(WDATA_I, pss_pkg::DELAY_MAX_MS);
                pss_pkg::REG_BASE_ADDR: next_r.base = WDATA_I[7:0];
                pss_pkg::REG_OV_RESP: next_r.ovr = WDATA_I[7:0];
                pss_pkg::REG_SS_OPT: next_r.opt = WDATA_I[7:0];
                default: ;
            endcase
        end
        case (ADDR_I)
            pss_pkg::REG_OPERATION: next_r.rd = {8'h00, r.op};
            pss_pkg::REG_ON_OFF_CFG: next_r.rd = {8'h00, r.cfg};
            pss_pkg::REG_UV_LIMIT: next_r.rd = r.uv;
            pss_pkg::REG_TON_DLY: next_r.rd = {3'h0, r.ton_d, 2'h0};
            pss_pkg::REG_TURN_ON_RISE_TIME: next_r.rd = {3'h0, r.ton_r, 2'h0};
            pss_pkg::REG_TOFF_DLY: next_r.rd = {3'h0, r.tof_d, 2'h0};
            pss_pkg::REG_TURN_OFF_FALL_TIME: next_r.rd = {3'h0, r.tof_f, 2'h0};
            pss_pkg::REG_BASE_ADDR: next_r.rd = {8'h00, r.base};
            pss_pkg::REG_OV_RESP: next_r.rd = {8'h00, r.ovr};
            pss_pkg::REG_SS_OPT: next_r.rd = {8'h00, r.opt};
            pss_pkg::REG_STATUS: next_r.rd = {7'h00, r.st};
            default: next_r.rd = 16'h0000;
        endcase

        // overvoltage: ignored before first load and while loading
        if (OV_I && r.loaded && r.st != S_LOAD && !r.ovr[pss_pkg::OV_IGNORE_BIT]) begin
            if (!r.ovr[pss_pkg::OV_DEB_BIT] || r.ov_seen) begin
                next_r.ovf = 1'b1;
                next_r.sw = 1'b0;
                next_r.ready = 1'b0;
                next_r.st = r.ovr[pss_pkg::OV_RELOAD_BIT] ? S_LOAD : S_OFF;
                next_r.load_req = r.ovr[pss_pkg::OV_RELOAD_BIT];
                next_r.ref_v = '0;
            end else if (tick) next_r.ov_seen = 1'b1;
        end else begin
            next_r.ov_seen = 1'b0;
            case (r.st)
                S_RESET: if (SUPPLY_OK_I) begin
                    next_r.st = S_LOAD;
                    next_r.load_req = 1'b1;
                end
                S_LOAD: if (LOAD_DONE_I) begin
                    next_r.loaded = 1'b1;
                    next_r.sa = {r.base[6:2], ADDR_PIN_I};
                    next_r.ms = 11'(pss_pkg::IDLE_MS) +
                        (ERASE_NEED_I ? 11'(pss_pkg::ERASE_MS) : 11'h000);
                    next_r.st = S_IDLE;
                end
                // one extra tick: the divider phase is free, so counting
                // down to zero keeps the idle span at least the full count
                S_IDLE: if (tick) begin
                    if (r.ms == 11'h000) begin
                        next_r.ready = 1'b1;
                        next_r.st = S_OFF;
                    end else next_r.ms = r.ms - 11'h001;
                end
                S_OFF: if (on_req) begin
                    next_r.ms = 11'h000;
                    next_r.st = S_ONDLY;
                end
                S_ONDLY: if (!on_req) next_r.st = S_OFF;
                else if (tick) begin
                    if (r.ms >= r.ton_d) begin
                        next_r.ms = 11'h000;
                        next_r.tmax = 11'h000;
                        next_r.sw = 1'b1;
                        next_r.start_v = r.opt[pss_pkg::PRECHARGE_BIT] ?
                            SENSE_I : '0;
                        next_r.ref_v = next_r.start_v;
                        next_r.st = S_RISE;
                    end else next_r.ms = r.ms + 11'h001;
                end
                S_RISE, S_ON: begin
                    if (tick) begin
                        next_r.ms = (r.ms == 11'h7FF) ? r.ms : r.ms + 11'h001;
                        next_r.tmax = (r.tmax == 11'h7FF) ? r.tmax : r.tmax + 11'h001;
                        // precharge: the smaller remaining span still takes the full ton_r
                        next_r.ref_v = pss_lerp(r.start_v, TARGET_I, next_r.ms,
                            r.ton_r);
                        if (next_r.ref_v == TARGET_I) next_r.st = S_ON;
                    end
                    if (r.uv != 16'h0000 && {4'h0, SENSE_I} <= r.uv[REF_W-1:0] &&
                        r.tmax >= r.ton_m && r.ton_m != 11'h000) begin
                        next_r.sf = 1'b1;
                        next_r.sw = 1'b0;
                        next_r.ref_v = '0;
                        next_r.st = S_OFF;
                    end else if (!on_req) begin
                        next_r.ms = 11'h000;
                        next_r.st = S_OFFDLY;
                    end
                end
                S_OFFDLY: if (tick) begin
                    if (r.ms >= r.tof_d) begin
                        next_r.ms = 11'h000;
                        next_r.tmax = 11'h000;
                        next_r.start_v = r.ref_v;
                        next_r.st = S_FALL;
                    end else next_r.ms = r.ms + 11'h001;
                end
                S_FALL: if (tick) begin
                    next_r.ms = r.ms + 11'h001;
                    next_r.tmax = r.tmax + 11'h001;
                    next_r.ref_v = pss_lerp(r.start_v, '0, next_r.ms,
                        r.tof_f);
                    if (next_r.ref_v == '0) begin
                        next_r.sw = 1'b0;
                        next_r.st = S_OFF;
                    end else if (r.tof_m != 11'h000 && r.tmax >= r.tof_m) begin
                        next_r.sf = 1'b1;
                        next_r.sw = 1'b0;
                        next_r.ref_v = '0;
                        next_r.st = S_OFF;
                    end
                end
                default: next_r.st = S_RESET;
            endcase
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r <= '0;
            r.st <= S_RESET;
            r.cfg <= pss_pkg::ON_OFF_RST;
            r.ovr <= pss_pkg::OV_RESP_RST;
        end else begin
            r <= next_r;
        end
    end

    assign LOAD_REQ_O = r.load_req;
    assign SLAVE_ADDR_O = r.sa;
    assign READY_O = r.ready;
    assign REF_O = r.ref_v;
    assign SWITCH_O = r.sw;
    assign START_FAULT_O = r.sf;
    assign OV_FAULT_O = r.ovf;
    assign RDATA_O = r.rd;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_no_ov_in_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (r.st == S_LOAD && !$past(OV_I)) |-> !$rose(r.ovf))
        else $error("overvoltage flagged during load");
    a_clamp_delay: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        r.ton_d <= pss_pkg::DELAY_MAX_MS && r.tof_d <= pss_pkg::DELAY_MAX_MS)
        else $error("delay above range");
    a_clamp_ramp: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        r.ton_r <= pss_pkg::RAMP_MAX_MS && r.tof_f <= pss_pkg::RAMP_MAX_MS)
        else $error("ramp above range");
    a_load_after_ok: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (r.st == S_RESET && SUPPLY_OK_I && !OV_I) |=> r.load_req)
        else $error("no load request");
    a_idle_wait: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(r.ready) |-> $past(r.st) == S_IDLE)
        else $error("ready without idle");
    a_ref_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (r.st == S_OFF || r.st == S_ONDLY) |-> r.ref_v == '0)
        else $error("reference live while off");
    a_no_uv_check: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (r.uv == 16'h0000 && r.st == S_RISE && !OV_I) |=> !$rose(r.sf))
        else $error("timeout with uv limit zero");
    a_always_on: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (r.st == S_OFF && !r.cfg[4] && !OV_I) |=> r.st == S_ONDLY)
        else $error("always on did not start");
endmodule // pss_top
